// File: luc_pkg.sv
// ==========================================
// shared constants and types
package luc_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'hc0;
	localparam logic [7:0] ADDR_STAT = 8'hc1;
	localparam logic [7:0] ADDR_ERR = 8'hc2;
	localparam logic [7:0] ADDR_LEN = 8'hc3;
	localparam logic [7:0] ADDR_BTR = 8'hc4;
	localparam logic [7:0] ADDR_DIVL = 8'hc5;
	localparam logic [7:0] ADDR_DIVH = 8'hc6;
	localparam logic [7:0] ADDR_DATA = 8'hc7;
	localparam logic [7:0] ADDR_ID = 8'hc8;
	// control field positions
	localparam int unsigned CTRL_SWRES = 7;
	localparam int unsigned CTRL_LEGACY = 6;
	localparam int unsigned CTRL_ENA = 3;
	// status field positions
	localparam int unsigned STB_RXDONE = 0;
	localparam int unsigned STB_TXDONE = 1;
	localparam int unsigned STB_ERR = 2;
	// reset values and samples per bit minimum
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [5:0] SPB_RST = 6'h20;
	localparam logic [11:0] DIV_RST = 12'h000;
	localparam logic [5:0] SPB_MIN = 6'h08;
	// idle cycles between bytes of a response
	localparam logic [1:0] GAP_CYC = 2'h3;
	localparam logic [2:0] BIT_LAST = 3'h7;
	// command codes
	typedef enum logic [2:0] {
		CMD_RX_HDR = 3'b000,
		CMD_TX_HDR = 3'b001,
		CMD_RX_RSP = 3'b010,
		CMD_TX_RSP = 3'b011,
		CMD_UART_OFF = 3'b100
	} luc_cmd_t;
	// byte engine states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_DATA = 3'b010,
		ST_PAR = 3'b011,
		ST_STOP = 3'b100
	} luc_state_t;
	// decoded frame configuration
	typedef struct packed {
		logic crc_on;
		logic tmo_on;
		logic listen;
		logic par_on;
		logic par_odd;
	} luc_cfg_t;
	// error flags, bits 3 down to 0
	typedef struct packed {
		logic sync;
		logic parity;
		logic checksum;
		logic bit_err;
	} luc_err_t;
	// register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} luc_bus_t;
endpackage

// File: luc_data_buf.sv
// ==========================================
// response byte buffer, registered read
module luc_data_buf (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic we,
	input wire logic [2:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [2:0] raddr,
	output logic [7:0] rdata
);
	logic [7:0] mem [8]; // eight data bytes

	// write port
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// read port, one cycle latency
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata <= 8'h00;
		end else begin
			rdata <= mem[raddr];
		end
	end
endmodule // luc_data_buf

// File: luc_lin_uart.sv
// ==========================================
// lin / uart controller core
// Contract
// - soft reset bit resets, then self-clears
// - legacy select: 0 rev 2.1, 1 rev 1.3
// - lin frame config picks checksum/timeout/listen
// - uart frame config picks parity/listen
// - enable low disables; commands need enable
// - codes 000-011 select lin operations
// - uart codes 100 off, 11x rx, 1x1 tx
// - rx response clears transmit length field
// - rx response: rx length held, tx counts
// - rx error stops, flags, count kept
// - rx done after checksum, lengths equal
// - tx response clears receive length field
// - tx response: tx length held, rx counts
// - tx error stops, flags, count kept
// - tx done after checksum, lengths equal
// - four error flags cleared with summary
// - resync disable bit stops resynchronisation
// - samples per bit default 32, 8..63
// - sample period is clock times divisor+1
// - twelve bit divisor, reset zero
module luc_lin_uart (
	input wire logic clk,
	input wire logic reset_n,
	input wire luc_pkg::luc_bus_t bus,
	output logic [7:0] rdata,
	input wire logic line_rx,
	output logic line_tx,
	output logic busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// ==========================================
	// decode helpers
	function automatic logic hit(input luc_pkg::luc_bus_t b,
		input logic [7:0] a);
		return b.wr && (b.addr == a);
	endfunction

	function automatic luc_pkg::luc_cfg_t decode_cfg(input logic uart,
		input logic [1:0] c);
		luc_pkg::luc_cfg_t r;
		r = '0;
		if (uart) begin
			r.par_on = (c == 2'b01) || (c == 2'b10);
			r.par_odd = (c == 2'b10);
			r.listen = (c == 2'b11);
		end else begin
			r.crc_on = (c != 2'b01);
			r.tmo_on = (c == 2'b00) || (c == 2'b11);
			r.listen = (c == 2'b11);
		end
		return r;
	endfunction

	function automatic logic [7:0] ck_add(input logic [7:0] a,
		input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[7:0] + {7'h00, s[8]};
	endfunction

	// ==========================================
	// declarations
	logic sw_reset; // one-cycle soft reset
	logic legacy; // rev 1.3 behaviour
	logic [1:0] conf; // frame configuration
	logic enable; // controller enable
	logic [2:0] cmd; // last command code
	logic resync_dis; // resynchronisation off
	logic [5:0] spb; // samples per bit
	logic [11:0] divisor; // baud divisor
	logic [7:0] lin_id; // identifier for checksum seed
	logic [3:0] rx_len, tx_len; // length fields
	logic rsp_tx; // response direction
	logic [7:0] ck; // running checksum
	logic rx_done, tx_done; // done flags
	luc_pkg::luc_err_t err; // sticky error flags
	logic uart_tx_pend; // uart byte queued
	logic [2:0] ptr; // software buffer pointer
	logic data_sel; // read of buffer pending
	logic [7:0] rdata_q; // registered register read
	logic [7:0] mem_q; // buffer read data
	logic rx_meta, rx_s, rx_prev; // line synchroniser
	luc_pkg::luc_state_t state; // byte engine state
	logic [11:0] div_cnt; // sample divider
	logic [5:0] samp; // sample index in bit
	logic [2:0] bitn; // data bit index
	logic [7:0] shreg; // shift register
	logic par_acc, smp, eng_tx; // engine state bits
	logic ev_byte; // byte finished clean
	luc_pkg::luc_err_t ev_err; // engine error pulse
	logic [1:0] gap; // inter-byte gap
	logic next_tx; // next line level

	luc_pkg::luc_cfg_t cfg;
	logic uart_mode, uart_rx_en, uart_tx_en;
	logic wr_ctrl, cmd_go, count_done, is_ck, ck_bad;
	logic tick, bit_end, mid, resync, par_bit;
	logic tx_req, rx_en, start_tx, start_rx, rsp_end;
	logic sw_wr, sw_rd, eng_wr, rx_set, tx_set, clr_st;
	logic [7:0] tx_byte;

	// ==========================================
	// combinational decode
	assign cfg = decode_cfg(uart_mode, conf);
	assign uart_mode = cmd[2];
	assign uart_rx_en = enable && (cmd[2:1] == 2'b11);
	assign uart_tx_en = enable && cmd[2] && cmd[0];
	assign wr_ctrl = hit(bus, luc_pkg::ADDR_CTRL);
	assign cmd_go = wr_ctrl && bus.wdata[luc_pkg::CTRL_ENA]
		&& !bus.wdata[luc_pkg::CTRL_SWRES];
	assign count_done = (rx_len == tx_len);
	assign is_ck = busy && cfg.crc_on && count_done;
	assign ck_bad = is_ck && !rsp_tx && (shreg != ~ck);
	assign tx_byte = is_ck ? ~ck : mem_q;
	assign tick = (div_cnt == divisor);
	assign bit_end = tick && (samp == spb - 6'h01);
	assign mid = tick && (samp == {1'b0, spb[5:1]});
	assign par_bit = par_acc ^ cfg.par_odd;
	assign tx_req = busy ? rsp_tx : uart_tx_pend;
	assign rx_en = busy ? !rsp_tx : uart_rx_en;
	assign start_tx = (state == luc_pkg::ST_IDLE) && (gap == 2'h0)
		&& tx_req && !(busy && !cfg.crc_on && count_done);
	assign start_rx = (state == luc_pkg::ST_IDLE) && rx_en
		&& rx_prev && !rx_s && !start_tx;
	assign resync = !resync_dis && (state == luc_pkg::ST_DATA)
		&& !eng_tx && rx_prev && !rx_s
		&& (samp < {1'b0, spb[5:1]});
	assign rsp_end = busy && !cfg.crc_on && count_done
		&& (state == luc_pkg::ST_IDLE) && (gap == 2'h0);
	assign sw_wr = hit(bus, luc_pkg::ADDR_DATA) && !busy;
	assign sw_rd = bus.rd && (bus.addr == luc_pkg::ADDR_DATA);
	assign eng_wr = ev_byte && !eng_tx && !(busy && is_ck);
	assign rx_set = (ev_byte && !eng_tx
		&& (busy ? (is_ck && !ck_bad) : uart_mode))
		|| (rsp_end && !rsp_tx);
	assign tx_set = (ev_byte && eng_tx && (busy ? is_ck : uart_mode))
		|| (rsp_end && rsp_tx);
	assign clr_st = hit(bus, luc_pkg::ADDR_STAT);

	// ==========================================
	// control register and soft reset
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sw_reset <= 1'b0;
		end else begin
			// self-clears one cycle after the write
			sw_reset <= wr_ctrl
				&& bus.wdata[luc_pkg::CTRL_SWRES];
		end
	end

	swres_self_clear_a: assert property (sw_reset |=> !sw_reset
		&& !busy && (cmd == 3'b000))
		else $error("soft reset did not self-clear");

	// control fields
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			{legacy, conf, enable, cmd} <= luc_pkg::CTRL_RST[6:0];
		end else if (sw_reset) begin
			{legacy, conf, enable, cmd} <= luc_pkg::CTRL_RST[6:0];
		end else if (wr_ctrl && !bus.wdata[luc_pkg::CTRL_SWRES]) begin
			{legacy, conf, enable, cmd} <= bus.wdata[6:0];
		end
	end

	// bit timing, divisor and identifier
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			resync_dis <= 1'b0;
			spb <= luc_pkg::SPB_RST;
			divisor <= luc_pkg::DIV_RST;
			lin_id <= 8'h00;
		end else if (sw_reset) begin
			resync_dis <= 1'b0;
			spb <= luc_pkg::SPB_RST;
			divisor <= luc_pkg::DIV_RST;
			lin_id <= 8'h00;
		end else begin
			if (hit(bus, luc_pkg::ADDR_BTR)) begin
				resync_dis <= bus.wdata[7];
				// counts below the minimum are ignored
				if (bus.wdata[5:0] >= luc_pkg::SPB_MIN) begin
					spb <= bus.wdata[5:0];
				end
			end
			if (hit(bus, luc_pkg::ADDR_DIVL)) begin
				divisor[7:0] <= bus.wdata;
			end
			if (hit(bus, luc_pkg::ADDR_DIVH)) begin
				divisor[11:8] <= bus.wdata[3:0];
			end
			if (hit(bus, luc_pkg::ADDR_ID)) begin
				lin_id <= bus.wdata;
			end
		end
	end

	spb_range_a: assert property (spb >= luc_pkg::SPB_MIN)
		else $error("samples per bit out of range");

	// ==========================================
	// response sequencing and length fields
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			busy <= 1'b0;
			rsp_tx <= 1'b0;
			rx_len <= 4'h0;
			tx_len <= 4'h0;
			ck <= 8'h00;
		end else if (sw_reset) begin
			busy <= 1'b0;
			rsp_tx <= 1'b0;
			rx_len <= 4'h0;
			tx_len <= 4'h0;
			ck <= 8'h00;
		end else if (wr_ctrl) begin
			// rev 2.1 seeds the sum with the identifier
			ck <= bus.wdata[luc_pkg::CTRL_LEGACY] ? 8'h00 : lin_id;
			if (cmd_go) begin
				case (bus.wdata[2:0])
				luc_pkg::CMD_RX_RSP: begin
					busy <= 1'b1;
					rsp_tx <= 1'b0;
					tx_len <= 4'h0;
				end
				luc_pkg::CMD_TX_RSP: begin
					busy <= 1'b1;
					rsp_tx <= 1'b1;
					rx_len <= 4'h0;
				end
				default: begin
					// header and uart codes end a response
					busy <= 1'b0;
				end
				endcase
			end else begin
				busy <= 1'b0;
			end
		end else if (busy) begin
			if (ev_err != '0) begin
				busy <= 1'b0;
			end else if (ev_byte && is_ck) begin
				busy <= 1'b0;
			end else if (ev_byte) begin
				ck <= ck_add(ck, shreg);
				if (rsp_tx) begin
					rx_len <= rx_len + 4'h1;
				end else begin
					tx_len <= tx_len + 4'h1;
				end
			end else if (rsp_end) begin
				busy <= 1'b0;
			end
		end else if (hit(bus, luc_pkg::ADDR_LEN)) begin
			// lengths are software's only while idle
			rx_len <= bus.wdata[3:0];
			tx_len <= bus.wdata[7:4];
		end
	end

	sequence s_rx_cmd;
		cmd_go && (bus.wdata[2:0] == 3'b010);
	endsequence
	sequence s_tx_cmd;
		cmd_go && (bus.wdata[2:0] == 3'b011);
	endsequence

	rx_cmd_a: assert property (s_rx_cmd |=> busy && !rsp_tx
		&& (tx_len == 4'h0))
		else $error("rx response did not clear tx length");
	tx_cmd_a: assert property (s_tx_cmd |=> busy && rsp_tx
		&& (rx_len == 4'h0))
		else $error("tx response did not clear rx length");
	rx_hold_a: assert property (busy && !rsp_tx && !wr_ctrl && !sw_reset
		|=> $stable(rx_len))
		else $error("rx length moved during rx response");
	tx_hold_a: assert property (busy && rsp_tx && !wr_ctrl && !sw_reset
		|=> $stable(tx_len))
		else $error("tx length moved during tx response");
	err_stop_a: assert property (busy && (ev_err != '0) && !wr_ctrl
		&& !sw_reset |=> !busy && (err != '0)
		&& $stable(rx_len) && $stable(tx_len))
		else $error("error did not stop response");
	enable_off_a: assert property (wr_ctrl
		&& !bus.wdata[luc_pkg::CTRL_ENA] |=> !busy)
		else $error("disable left response running");

	// ==========================================
	// flags: set wins over clear
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_done <= 1'b0;
			tx_done <= 1'b0;
			err <= '0;
		end else if (sw_reset) begin
			rx_done <= 1'b0;
			tx_done <= 1'b0;
			err <= '0;
		end else begin
			rx_done <= rx_set || (rx_done
				&& !(clr_st && bus.wdata[luc_pkg::STB_RXDONE]));
			tx_done <= tx_set || (tx_done
				&& !(clr_st && bus.wdata[luc_pkg::STB_TXDONE]));
			// clearing the summary clears all four
			err <= ev_err | {2'b00, ck_bad && ev_byte, 1'b0}
				| (err & {4{!(clr_st
				&& bus.wdata[luc_pkg::STB_ERR])}});
		end
	end

	rx_done_a: assert property ($rose(rx_done) && !uart_mode && !rsp_tx
		|-> (rx_len == tx_len))
		else $error("rx done with unequal lengths");
	tx_done_a: assert property ($rose(tx_done) && !uart_mode && rsp_tx
		|-> (rx_len == tx_len))
		else $error("tx done with unequal lengths");
	err_clear_a: assert property (clr_st && bus.wdata[luc_pkg::STB_ERR]
		&& (ev_err == '0) && !ev_byte |=> (err == '0))
		else $error("summary clear left error flags");

	// ==========================================
	// line input synchroniser
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_meta <= 1'b1;
			rx_s <= 1'b1;
			rx_prev <= 1'b1;
		end else begin
			rx_meta <= line_rx;
			rx_s <= rx_meta;
			rx_prev <= rx_s;
		end
	end

	// ==========================================
	// sample timing
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_cnt <= 12'h000;
			samp <= 6'h00;
			smp <= 1'b1;
		end else if (sw_reset || start_tx || start_rx || resync) begin
			div_cnt <= 12'h000;
			samp <= 6'h00;
		end else begin
			// one sample every divisor+1 clocks
			div_cnt <= tick ? 12'h000 : div_cnt + 12'h001;
			if (tick) begin
				samp <= (samp == spb - 6'h01) ? 6'h00 : samp + 6'h01;
			end
			if (mid) begin
				smp <= rx_s;
			end
		end
	end

	// ==========================================
	// byte engine
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= luc_pkg::ST_IDLE;
			bitn <= 3'h0;
			shreg <= 8'h00;
			par_acc <= 1'b0;
			eng_tx <= 1'b0;
			ev_byte <= 1'b0;
			ev_err <= '0;
		end else begin
			ev_byte <= 1'b0;
			ev_err <= '0;
			if (sw_reset || wr_ctrl) begin
				state <= luc_pkg::ST_IDLE;
			end else begin
				case (state)
				luc_pkg::ST_IDLE: begin
					par_acc <= 1'b0;
					bitn <= 3'h0;
					if (start_tx) begin
						shreg <= tx_byte;
						eng_tx <= 1'b1;
						state <= luc_pkg::ST_START;
					end else if (start_rx) begin
						eng_tx <= 1'b0;
						state <= luc_pkg::ST_START;
					end
				end
				luc_pkg::ST_START: begin
					if (bit_end && smp) begin
						// false start or start bit overdriven
						ev_err.bit_err <= eng_tx && !cfg.listen;
						state <= luc_pkg::ST_IDLE;
					end else if (bit_end) begin
						state <= luc_pkg::ST_DATA;
					end
				end
				luc_pkg::ST_DATA: begin
					if (bit_end) begin
						shreg <= {smp, shreg[7:1]};
						par_acc <= par_acc ^ smp;
						bitn <= bitn + 3'h1;
						if (eng_tx && !cfg.listen && smp != shreg[0]) begin
							ev_err.bit_err <= 1'b1;
							state <= luc_pkg::ST_IDLE;
						end else if (bitn == luc_pkg::BIT_LAST) begin
							state <= cfg.par_on ? luc_pkg::ST_PAR
								: luc_pkg::ST_STOP;
						end
					end
				end
				luc_pkg::ST_PAR: begin
					if (bit_end && smp != par_bit) begin
						ev_err.parity <= !eng_tx;
						ev_err.bit_err <= eng_tx && !cfg.listen;
						state <= luc_pkg::ST_IDLE;
					end else if (bit_end) begin
						state <= luc_pkg::ST_STOP;
					end
				end
				luc_pkg::ST_STOP: begin
					if (bit_end) begin
						// low stop bit on receive counts as loss of sync
						ev_err.sync <= !smp && !eng_tx;
						ev_err.bit_err <= !smp && eng_tx && !cfg.listen;
						ev_byte <= smp || (eng_tx && cfg.listen);
						state <= luc_pkg::ST_IDLE;
					end
				end
				default: begin
					state <= luc_pkg::ST_IDLE;
				end
				endcase
			end
		end
	end

	// next line level; listening never drives
	always_comb begin
		next_tx = 1'b1;
		if (eng_tx && !cfg.listen) begin
			case (state)
			luc_pkg::ST_START: next_tx = 1'b0;
			luc_pkg::ST_DATA: next_tx = shreg[0];
			luc_pkg::ST_PAR: next_tx = par_bit;
			default: next_tx = 1'b1;
			endcase
		end
	end

	// line output and inter-byte gap
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			line_tx <= 1'b1;
			gap <= 2'h0;
		end else begin
			line_tx <= next_tx;
			// a buffer write also waits: read flop lags the write by two
			if (state != luc_pkg::ST_IDLE || cmd_go || sw_wr) begin
				gap <= luc_pkg::GAP_CYC;
			end else if (gap != 2'h0) begin
				gap <= gap - 2'h1;
			end
		end
	end

	listen_quiet_a: assert property (cfg.listen ##1 cfg.listen
		|-> line_tx)
		else $error("line driven in listening mode");

	// ==========================================
	// uart queue and buffer pointer
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			uart_tx_pend <= 1'b0;
			ptr <= 3'h0;
		end else if (sw_reset || wr_ctrl) begin
			uart_tx_pend <= 1'b0;
			ptr <= 3'h0;
		end else begin
			if (sw_wr && uart_tx_en) begin
				uart_tx_pend <= 1'b1;
			end else if (start_tx && !busy) begin
				uart_tx_pend <= 1'b0;
			end
			if ((sw_wr || sw_rd) && !uart_mode && !busy) begin
				ptr <= ptr + 3'h1;
			end
		end
	end

	luc_data_buf u_buf (
		.clk(clk),
		.reset_n(reset_n),
		.we(eng_wr || sw_wr),
		.waddr(busy ? tx_len[2:0] : ptr),
		.wdata(eng_wr ? shreg : bus.wdata),
		.raddr(busy ? rx_len[2:0] : ptr),
		.rdata(mem_q)
	);

	// ==========================================
	// register read, data one cycle after strobe
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_q <= 8'h00;
			data_sel <= 1'b0;
		end else begin
			data_sel <= sw_rd;
			rdata_q <= 8'h00;
			if (!bus.rd) begin
				rdata_q <= 8'h00;
			end else if (bus.addr == luc_pkg::ADDR_CTRL) begin
				rdata_q <= {sw_reset, legacy, conf, enable, cmd};
			end else if (bus.addr == luc_pkg::ADDR_STAT) begin
				rdata_q <= {1'b0, cfg.tmo_on, cfg.crc_on, busy, 1'b0,
					err != '0, tx_done, rx_done};
			end else if (bus.addr == luc_pkg::ADDR_ERR) begin
				rdata_q <= {4'h0, err};
			end else if (bus.addr == luc_pkg::ADDR_LEN) begin
				rdata_q <= {tx_len, rx_len};
			end else if (bus.addr == luc_pkg::ADDR_BTR) begin
				rdata_q <= {resync_dis, 1'b0, spb};
			end else if (bus.addr == luc_pkg::ADDR_DIVL) begin
				rdata_q <= divisor[7:0];
			end else if (bus.addr == luc_pkg::ADDR_DIVH) begin
				rdata_q <= {4'h0, divisor[11:8]};
			end else if (bus.addr == luc_pkg::ADDR_ID) begin
				rdata_q <= lin_id;
			end
		end
	end

	assign rdata = data_sel ? mem_q : rdata_q;
endmodule // luc_lin_uart

// File: luc_line_peer.sv
// ==========================================
// far side: one lin node on a wired-and bus
module luc_line_peer #(
	parameter int BIT_CYC = 8
) (
	input wire logic clk,
	input wire logic line_tx,
	output logic line_rx
);
	timeunit 1ns;
	timeprecision 1ns;
	logic drv = 1'b1; // peer drive, 1 = released
	// bus with pull-up: dominant wins, device hears itself
	assign line_rx = line_tx & drv;
	// ==========================================
	// send one frame, stop level selectable
	task automatic send(input logic [7:0] b, input logic stp);
		logic [9:0] f;
		f = {stp, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			drv <= f[i];
			repeat (BIT_CYC) @(posedge clk);
		end
		drv <= 1'b1;
		// one idle bit so the device can close the frame before the caller
		repeat (BIT_CYC) @(posedge clk);
	endtask
	// ==========================================
	// capture n bits of a device frame, lsb first
	task automatic recv(input int n, output logic [10:0] bits);
		int w;
		bits = '0;
		for (w = 0; w < 400 && line_tx; w++) @(negedge clk);
		if (!line_tx) begin
			repeat (BIT_CYC / 2) @(negedge clk);
			for (int i = 0; i < n; i++) begin
				bits[i] = line_tx;
				repeat (BIT_CYC) @(negedge clk);
			end
		end
	endtask
	// ==========================================
	// hold the bus dominant over one bit of a device frame
	task automatic jam(input int at);
		int w;
		for (w = 0; w < 400 && line_tx; w++) @(negedge clk);
		repeat (at) @(negedge clk);
		drv <= 1'b0;
		repeat (BIT_CYC) @(negedge clk);
		drv <= 1'b1;
	endtask
endmodule // luc_line_peer

// File: test_lin_uart_controller.sv
// ==========================================
// register level bench for the lin / uart core
module test_lin_uart_controller;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0; // 50 mhz
	logic reset_n = 1'b0; // held low at start
	luc_pkg::luc_bus_t bus = '0; // register request
	logic [7:0] rdata;
	logic line_rx;
	logic line_tx;
	logic busy;
	int errors = 0;
	int checks = 0;
	logic [10:0] frm; // captured frame bits
	logic [7:0] cfg_exp [4] = '{8'h60, 8'h00, 8'h20, 8'h60};

	always #10 clk = ~clk;

	luc_lin_uart luc_lin_uart_inst (
		.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
		.line_rx(line_rx), .line_tx(line_tx), .busy(busy)
	);
	luc_line_peer #(.BIT_CYC(8)) luc_line_peer_inst (
		.clk(clk), .line_tx(line_tx), .line_rx(line_rx)
	);

	// ==========================================
	// verdict and end of run
	task automatic final_report();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// compare one value
	task automatic chk(input string what, input logic [10:0] exp,
		input logic [10:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// one cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge clk);
		bus.wr <= 1'b0;
	endtask
	// read strobe, data taken in the following cycle
	task automatic rchk(input string what, input logic [7:0] a,
		input logic [7:0] exp, input logic [7:0] m = 8'hff);
		logic [7:0] d;
		@(posedge clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge clk);
		bus.rd <= 1'b0;
		@(negedge clk);
		d = rdata;
		chk(what, {3'b0, exp & m}, {3'b0, d & m});
	endtask
	// bounded wait for the response to end
	task automatic wait_idle();
		int n;
		for (n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge clk);
		if (busy !== 1'b0) begin
			errors++;
			final_report();
		end
	endtask

	// ==========================================
	// hang guard
	initial begin
		repeat (60000) @(posedge clk);
		errors++;
		final_report();
	end

	// ==========================================
	// main sequence
	initial begin
		repeat (3) @(posedge clk);
		reset_n <= 1'b1;
		rchk("ctrl", 8'hc0, 8'h00);
		rchk("timing", 8'hc4, 8'h20);
		rchk("div_lo", 8'hc5, 8'h00);
		rchk("div_hi", 8'hc6, 8'h00);
		rchk("unmapped", 8'hd0, 8'h00);
		wr(8'hc6, 8'hff);
		rchk("div_hi", 8'hc6, 8'h0f, 8'h0f);
		wr(8'hc6, 8'h00);
		// spb below 8 refused, resync bit still taken
		wr(8'hc4, 8'h87);
		rchk("timing", 8'hc4, 8'ha0);
		wr(8'hc4, 8'h3f);
		rchk("timing", 8'hc4, 8'h3f);
		wr(8'hc4, 8'h08);
		rchk("timing", 8'hc4, 8'h08);
		// lin frame configurations
		for (int c = 0; c < 4; c++) begin
			wr(8'hc0, {2'b00, 2'(c), 4'b1000});
			rchk("cfg", 8'hc1, cfg_exp[c], 8'h60);
		end
		// command ignored while disabled
		wr(8'hc3, 8'h15);
		wr(8'hc0, 8'h03);
		repeat (4) @(negedge clk);
		chk("busy off", 11'h0, {10'h0, busy});
		rchk("len", 8'hc3, 8'h15);
		// tx response of two bytes
		wr(8'hc3, 8'h25);
		wr(8'hc7, 8'h3c);
		wr(8'hc7, 8'hc3);
		wr(8'hc0, 8'h4b);
		@(negedge clk);
		chk("busy on", 11'h1, {10'h0, busy});
		luc_line_peer_inst.recv(10, frm);
		chk("tx frame", {2'b01, 8'h3c, 1'b0}, frm);
		rchk("len mid", 8'hc3, 8'h21);
		wait_idle();
		rchk("status", 8'hc1, 8'h02, 8'h07);
		rchk("len end", 8'hc3, 8'h22);
		wr(8'hc1, 8'h07);
		// rx response of one byte plus checksum
		wr(8'hc3, 8'h31);
		wr(8'hc0, 8'h4a);
		rchk("len clr", 8'hc3, 8'h01);
		luc_line_peer_inst.send(8'h55, 1'b1);
		rchk("len mid", 8'hc3, 8'h11);
		luc_line_peer_inst.send(8'haa, 1'b1);
		wait_idle();
		rchk("status", 8'hc1, 8'h01, 8'h07);
		rchk("len end", 8'hc3, 8'h11);
		wr(8'hc1, 8'h07);
		// rx response broken by a low stop bit
		wr(8'hc3, 8'h02);
		wr(8'hc0, 8'h4a);
		luc_line_peer_inst.send(8'h12, 1'b0);
		wait_idle();
		rchk("status", 8'hc1, 8'h04, 8'h07);
		rchk("errors", 8'hc2, 8'h08);
		rchk("len", 8'hc3, 8'h02);
		wr(8'hc1, 8'h04);
		rchk("errors", 8'hc2, 8'h00);
		// rev 2.1 sum seeded by the identifier, unseeded sum refused
		wr(8'hc8, 8'h10);
		wr(8'hc3, 8'h01);
		wr(8'hc0, 8'h0a);
		luc_line_peer_inst.send(8'h20, 1'b1);
		luc_line_peer_inst.send(8'hdf, 1'b1);
		wait_idle();
		rchk("errors", 8'hc2, 8'h02);
		wr(8'hc1, 8'h07);
		// tx response broken by a dominant peer
		wr(8'hc3, 8'h20);
		wr(8'hc7, 8'hff);
		wr(8'hc7, 8'hff);
		wr(8'hc0, 8'h4b);
		luc_line_peer_inst.jam(9);
		wait_idle();
		rchk("errors", 8'hc2, 8'h01);
		rchk("len", 8'hc3, 8'h20);
		wr(8'hc1, 8'h07);
		// uart transmit, even then odd parity
		wr(8'hc0, 8'h1d);
		wr(8'hc7, 8'ha5);
		luc_line_peer_inst.recv(11, frm);
		chk("uart even", {2'b10, 8'ha5, 1'b0}, frm);
		repeat (20) @(posedge clk);
		rchk("status", 8'hc1, 8'h02, 8'h02);
		wr(8'hc0, 8'h2d);
		wr(8'hc7, 8'ha5);
		luc_line_peer_inst.recv(11, frm);
		chk("uart odd", {2'b11, 8'ha5, 1'b0}, frm);
		repeat (20) @(posedge clk);
		// uart receive enabled, then disabled
		wr(8'hc1, 8'h07);
		wr(8'hc0, 8'h0e);
		luc_line_peer_inst.send(8'h3c, 1'b1);
		repeat (10) @(posedge clk);
		rchk("status", 8'hc1, 8'h01, 8'h01);
		rchk("uart data", 8'hc7, 8'h3c);
		wr(8'hc0, 8'h0c);
		wr(8'hc1, 8'h07);
		luc_line_peer_inst.send(8'h3c, 1'b1);
		repeat (10) @(posedge clk);
		rchk("status", 8'hc1, 8'h00, 8'h01);
		// software reset returns defaults
		wr(8'hc4, 8'h88);
		wr(8'hc0, 8'h80);
		repeat (3) @(posedge clk);
		rchk("ctrl", 8'hc0, 8'h00);
		rchk("timing", 8'hc4, 8'h20);
		final_report();
	end
endmodule // test_lin_uart_controller
